// ---- verilog/phy_timing_regs.sv ----
// indirect timing override and raw justify register bank
//
// Function
// RULE_01: clock trail: auto, or bits 3:0 if bit7
// RULE_02: clock post: auto, or bits 5:0 if bit7
// RULE_03: data prepare: auto, or bits 4:0 if bit7
// RULE_04: data zero: auto, or bits 4:0 if bit7
// RULE_05: data trail: auto, or bits 3:0 if bit7
// RULE_06: data exit: auto, or bits 4:0 if bit7
// RULE_07: low power period: auto, or bits 3:0
// RULE_08: justify bit clear puts raw on lsbs
// RULE_09: justify bit set puts raw on msbs
// RULE_10: access through index port and data port
// RULE_11: all reset zero; reserved bits read back
`timescale 1ns/10ps
module phy_timing_regs import phy_cfg_pkg::*; #(
  parameter int RAW_W = 12,
  parameter int RGB_W = 24
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire host_access_t HOST,
  output logic [7:0] INDEX_RDATA,
  output logic [7:0] DATA_RDATA,
  input wire timing_t AUTO_TIMING,
  output wire timing_t TIMING,
  input wire logic [RAW_W-1:0] RAW_SAMPLE,
  output logic [RGB_W-1:0] RGB_BUS
);

  // ********************************************************
  // index port and decode
  // ********************************************************
  logic [7:0] index_reg;
  logic [7:0] bank_reg [BANK_DEPTH];
  logic [7:0] data_rdata_next;
  logic [RGB_W-1:0] rgb_next;

  // the index outside 02h..09h hits nothing: writes drop, reads give zero
  wire in_bank = (index_reg >= BANK_FIRST) && (index_reg <= BANK_LAST);
  wire [7:0] bank_ofs = index_reg - BANK_FIRST;
  wire [2:0] bank_sel = bank_ofs[2:0];
  wire bank_we = HOST.data_wr && in_bank; // RULE_10
  wire raw_high = bank_reg[RAW_ENTRY][RAW_JUSTIFY_BIT];

  assign data_rdata_next = in_bank ? bank_reg[bank_sel] : UNMAPPED_READ;

  // index register; a data access in the same cycle uses the old index
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      index_reg <= REG_RESET;
      INDEX_RDATA <= REG_RESET;
    end else begin
      if (HOST.index_wr) begin
        index_reg <= HOST.wdata; // RULE_10
        INDEX_RDATA <= HOST.wdata;
      end
    end
  end

  // ********************************************************
  // register bank
  // ********************************************************
  // whole byte stored, reserved bits included, so software reads back
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      for (int k = 0; k < BANK_DEPTH; k++) begin
        bank_reg[k] <= REG_RESET; // RULE_11
      end
    end else begin
      if (bank_we) begin
        bank_reg[bank_sel] <= HOST.wdata; // RULE_11
      end
    end
  end

  // read data holds until the next read strobe
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      DATA_RDATA <= REG_RESET;
    end else begin
      if (HOST.data_rd) begin
        DATA_RDATA <= data_rdata_next; // RULE_10
      end
    end
  end

  // ********************************************************
  // timing override selection
  // ********************************************************
  // entries 0..6 map one to one onto the timing fields
  for (genvar i = 0; i < NUM_TIMING; i++) begin : g_timing
    localparam int W = FIELD_W[i];
    localparam int L = FIELD_LSB[i];
    logic [W-1:0] sel_val;
    timing_select #(.WIDTH(W)) u_sel (
      .clk(CORE_CLK),
      .rst(RESET),
      .cfg_byte(bank_reg[i]), // RULE_01 RULE_02 RULE_03 RULE_04
      .auto_val(AUTO_TIMING[L +: W]), // RULE_05 RULE_06 RULE_07
      .sel_reg(sel_val)
    );
    assign TIMING[L +: W] = sel_val;
  end

  // ********************************************************
  // raw pixel justification
  // ********************************************************
  // unused bus bits are zero so downstream packing stays clean
  assign rgb_next = raw_high ?
    {RAW_SAMPLE, {(RGB_W-RAW_W){1'b0}}} : // RULE_09
    {{(RGB_W-RAW_W){1'b0}}, RAW_SAMPLE}; // RULE_08

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      RGB_BUS <= '0;
    end else begin
      RGB_BUS <= rgb_next;
    end
  end

  // ********************************************************
  // checks
  // ********************************************************
  clk_trail_sel_a: assert property ( // RULE_01
    @(posedge CORE_CLK) disable iff (RESET)
    !$past(RESET) |-> TIMING.clk_trail == ($past(bank_reg[0][7]) ?
      $past(bank_reg[0][3:0]) : $past(AUTO_TIMING.clk_trail)))
    else $error("clock trail selection wrong");

  clk_post_sel_a: assert property ( // RULE_02
    @(posedge CORE_CLK) disable iff (RESET)
    $past(bank_reg[1][7]) && !$past(RESET) |->
      TIMING.clk_post == $past(bank_reg[1][5:0]))
    else $error("clock post override not applied");

  clk_post_auto_a: assert property ( // RULE_02
    @(posedge CORE_CLK) disable iff (RESET)
    !bank_reg[1][7] |=> TIMING.clk_post == $past(AUTO_TIMING.clk_post))
    else $error("clock post not automatic");

  dat_prepare_ovr_a: assert property ( // RULE_03
    @(posedge CORE_CLK) disable iff (RESET)
    bank_reg[2][7] |=> TIMING.dat_prepare == $past(bank_reg[2][4:0]))
    else $error("data prepare override not applied");

  dat_prepare_sel_a: assert property ( // RULE_03
    @(posedge CORE_CLK) disable iff (RESET)
    !bank_reg[2][7] && !RESET |=>
      TIMING.dat_prepare == $past(AUTO_TIMING.dat_prepare))
    else $error("data prepare not automatic");

  dat_zero_sel_a: assert property ( // RULE_04
    @(posedge CORE_CLK) disable iff (RESET)
    bank_reg[3][7] |=> TIMING.dat_zero == $past(bank_reg[3][4:0]))
    else $error("data zero override not applied");

  dat_zero_auto_a: assert property ( // RULE_04
    @(posedge CORE_CLK) disable iff (RESET)
    !bank_reg[3][7] |=> TIMING.dat_zero == $past(AUTO_TIMING.dat_zero))
    else $error("data zero not automatic");

  dat_trail_sel_a: assert property ( // RULE_05
    @(posedge CORE_CLK) disable iff (RESET)
    !$past(RESET) |-> TIMING.dat_trail == ($past(bank_reg[4][7]) ?
      $past(bank_reg[4][3:0]) : $past(AUTO_TIMING.dat_trail)))
    else $error("data trail selection wrong");

  dat_exit_sel_a: assert property ( // RULE_06
    @(posedge CORE_CLK) disable iff (RESET)
    bank_reg[5][7] |=> TIMING.dat_exit == $past(bank_reg[5][4:0]))
    else $error("data exit override not applied");

  dat_exit_auto_a: assert property ( // RULE_06
    @(posedge CORE_CLK) disable iff (RESET)
    !bank_reg[5][7] |=> TIMING.dat_exit == $past(AUTO_TIMING.dat_exit))
    else $error("data exit not automatic");

  lp_period_sel_a: assert property ( // RULE_07
    @(posedge CORE_CLK) disable iff (RESET)
    !bank_reg[6][7] |=> TIMING.lp_period == $past(AUTO_TIMING.lp_period))
    else $error("low power period not automatic");

  lp_period_ovr_a: assert property ( // RULE_07
    @(posedge CORE_CLK) disable iff (RESET)
    bank_reg[6][7] |=> TIMING.lp_period == $past(bank_reg[6][3:0]))
    else $error("low power period override not applied");

  raw_low_justify_a: assert property ( // RULE_08
    @(posedge CORE_CLK) disable iff (RESET)
    !raw_high |=> RGB_BUS == {{(RGB_W-RAW_W){1'b0}}, $past(RAW_SAMPLE)})
    else $error("raw sample not on low bits");

  raw_high_justify_a: assert property ( // RULE_09
    @(posedge CORE_CLK) disable iff (RESET)
    raw_high |=> RGB_BUS[RGB_W-1 -: RAW_W] == $past(RAW_SAMPLE))
    else $error("raw sample not on high bits");

  raw_high_pad_a: assert property ( // RULE_09
    @(posedge CORE_CLK) disable iff (RESET)
    raw_high |=> RGB_BUS[RGB_W-RAW_W-1:0] == '0)
    else $error("low bits not clear with high justify");

  index_load_a: assert property ( // RULE_10
    @(posedge CORE_CLK) disable iff (RESET)
    HOST.index_wr |=> INDEX_RDATA == $past(HOST.wdata))
    else $error("index not loaded");

  unmapped_read_a: assert property ( // RULE_10
    @(posedge CORE_CLK) disable iff (RESET)
    HOST.data_rd && !in_bank |=> DATA_RDATA == UNMAPPED_READ)
    else $error("unmapped read not zero");

  read_hold_a: assert property ( // RULE_10
    @(posedge CORE_CLK) disable iff (RESET)
    !HOST.data_rd |=> $stable(DATA_RDATA))
    else $error("read data moved without a read");

  sequence wr_then_rd_s;
    HOST.data_wr && in_bank && !HOST.index_wr
    ##1 HOST.data_rd && !HOST.data_wr && !HOST.index_wr;
  endsequence

  indirect_readback_a: assert property ( // RULE_10
    @(posedge CORE_CLK) disable iff (RESET)
    wr_then_rd_s |=> DATA_RDATA == $past(HOST.wdata, 2))
    else $error("indirect write not read back");

  reset_auto_mode_a: assert property ( // RULE_11
    @(posedge CORE_CLK) disable iff (RESET)
    $past(RESET) |=> TIMING == $past(AUTO_TIMING) &&
      RGB_BUS == {{(RGB_W-RAW_W){1'b0}}, $past(RAW_SAMPLE)})
    else $error("bank not in automatic mode after reset");

endmodule

// ---- verilog/phy_cfg_pkg.sv ----
// shared constants and types for the phy timing override bank
package phy_cfg_pkg;

  // ********************************************************
  // indirect register offsets
  // ********************************************************
  localparam logic [7:0] CLK_LANE_TRAIL_TIME_OFS = 8'h02;
  localparam logic [7:0] CLK_LANE_POST_TIME_OFS = 8'h03;
  localparam logic [7:0] DATA_LANE_PREPARE_TIME_OFS = 8'h04;
  localparam logic [7:0] DATA_LANE_ZERO_TIME_OFS = 8'h05;
  localparam logic [7:0] DATA_LANE_TRAIL_TIME_OFS = 8'h06;
  localparam logic [7:0] DATA_LANE_EXIT_TIME_OFS = 8'h07;
  localparam logic [7:0] LOW_POWER_PERIOD_OFS = 8'h08;
  localparam logic [7:0] RAW_PIXEL_JUSTIFY_OFS = 8'h09;

  // ********************************************************
  // bank shape, fields and reset values
  // ********************************************************
  localparam int BANK_DEPTH = 8;
  localparam int NUM_TIMING = 7;
  localparam logic [7:0] BANK_FIRST = CLK_LANE_TRAIL_TIME_OFS;
  localparam logic [7:0] BANK_LAST = RAW_PIXEL_JUSTIFY_OFS;
  localparam logic [2:0] RAW_ENTRY = 3'h7;
  localparam int OVERRIDE_BIT = 7;
  localparam int RAW_JUSTIFY_BIT = 4;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // value field widths, in bank entry order
  localparam int CLK_TRAIL_W = 4;
  localparam int CLK_POST_W = 6;
  localparam int DAT_PREPARE_W = 5;
  localparam int DAT_ZERO_W = 5;
  localparam int DAT_TRAIL_W = 4;
  localparam int DAT_EXIT_W = 5;
  localparam int LP_PERIOD_W = 4;
  localparam int FIELD_W [NUM_TIMING] = '{CLK_TRAIL_W, CLK_POST_W,
    DAT_PREPARE_W, DAT_ZERO_W, DAT_TRAIL_W, DAT_EXIT_W, LP_PERIOD_W};
  // bit position of each field inside timing_t
  localparam int FIELD_LSB [NUM_TIMING] = '{29, 23, 18, 13, 9, 4, 0};

  // ********************************************************
  // carriers
  // ********************************************************
  typedef struct packed {
    logic [CLK_TRAIL_W-1:0] clk_trail;
    logic [CLK_POST_W-1:0] clk_post;
    logic [DAT_PREPARE_W-1:0] dat_prepare;
    logic [DAT_ZERO_W-1:0] dat_zero;
    logic [DAT_TRAIL_W-1:0] dat_trail;
    logic [DAT_EXIT_W-1:0] dat_exit;
    logic [LP_PERIOD_W-1:0] lp_period;
  } timing_t;

  typedef struct packed {
    logic index_wr;
    logic data_wr;
    logic data_rd;
    logic [7:0] wdata;
  } host_access_t;

endpackage

// ---- verilog/timing_select.sv ----
// one timing parameter: automatic value or software override
`timescale 1ns/10ps
module timing_select import phy_cfg_pkg::*; #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] cfg_byte,
  input wire logic [WIDTH-1:0] auto_val,
  output logic [WIDTH-1:0] sel_reg
);

  // ********************************************************
  // selection
  // ********************************************************
  wire override_on = cfg_byte[OVERRIDE_BIT];
  wire [WIDTH-1:0] sel_next = override_on ? cfg_byte[WIDTH-1:0] : auto_val;

  // registered so the transmitter sees a glitch-free value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_reg <= '0;
    end else begin
      sel_reg <= sel_next;
    end
  end

endmodule

// ---- testbench/phy_timing_regs_test.sv ----
// self-checking bench for the phy timing override register bank
`timescale 1ns/10ps
module phy_timing_regs_test import phy_cfg_pkg::*;;
  logic core_clk;
  logic reset;
  host_access_t host;
  logic [7:0] index_rdata;
  logic [7:0] data_rdata;
  timing_t auto_timing;
  timing_t timing;
  logic [11:0] raw_sample;
  logic [23:0] rgb_bus;
  int error_cnt;
  int n_tests;
  int cycles;

  phy_timing_regs #(.RAW_W(12), .RGB_W(24)) phy_timing_regs_i (
    .CORE_CLK(core_clk),
    .RESET(reset),
    .HOST(host),
    .INDEX_RDATA(index_rdata),
    .DATA_RDATA(data_rdata),
    .AUTO_TIMING(auto_timing),
    .TIMING(timing),
    .RAW_SAMPLE(raw_sample),
    .RGB_BUS(rgb_bus)
  );

  // ********************************************************
  // shared helpers
  // ********************************************************
  // inputs move 1 ns after the edge so no race with the design
  task tick;
    @(posedge core_clk);
    #1;
  endtask

  task chk(input string what, input logic [32:0] exp,
           input logic [32:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task put_index(input logic [7:0] v);
    host.index_wr = 1'b1;
    host.wdata = v;
    tick;
    host.index_wr = 1'b0;
    chk("index readback", 33'(v), 33'(index_rdata));
  endtask

  task put_data(input logic [7:0] v);
    host.data_wr = 1'b1;
    host.wdata = v;
    tick;
    host.data_wr = 1'b0;
  endtask

  task get_data(input logic [7:0] exp, input string what);
    host.data_rd = 1'b1;
    tick;
    host.data_rd = 1'b0;
    chk(what, 33'(exp), 33'(data_rdata));
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ********************************************************
  // scenarios
  // ********************************************************
  // every entry zero, so auto timing and low justify
  task reset_values;
    for (int i = 2; i <= 9; i++) begin
      put_index(8'(i));
      get_data(8'h00, "reset value");
    end
    chk("timing auto", auto_timing, timing);
    chk("rgb after reset", 33'(raw_sample), 33'(rgb_bus));
  endtask

  // all ones differs from the alternating auto pattern in every field
  task override_each;
    logic [32:0] m;
    for (int i = 0; i < NUM_TIMING; i++) begin
      m = ((33'h1 << FIELD_W[i]) - 33'h1) << FIELD_LSB[i];
      put_index(BANK_FIRST + 8'(i));
      put_data(8'hff);
      // read straight after the write, so the readback path is hit
      get_data(8'hff, "reserved bits");
      chk("override on", auto_timing | m, timing);
      put_data(8'h7f);
      tick;
      chk("override off", auto_timing, timing);
      put_data(8'h00);
    end
    chk("timing cleared", auto_timing, timing);
  endtask

  task raw_justify;
    raw_sample = 12'ha5c;
    put_index(RAW_PIXEL_JUSTIFY_OFS);
    put_data(8'hef);
    tick;
    chk("rgb low", {21'h0, 12'ha5c}, 33'(rgb_bus));
    put_data(8'h10);
    tick;
    chk("rgb high", {9'h0, 12'ha5c, 12'h0}, 33'(rgb_bus));
  endtask

  // writes outside 02h..09h vanish and read as zero
  task unmapped;
    logic [7:0] bad [4];
    bad = '{8'h00, 8'h01, 8'h0a, 8'hff};
    foreach (bad[k]) begin
      put_index(bad[k]);
      // override bit set, so a stray hit would show on the timing bus
      put_data(8'hda);
      get_data(8'h00, "unmapped read");
    end
    put_index(RAW_PIXEL_JUSTIFY_OFS);
    get_data(8'h10, "bank kept");
    chk("timing kept", auto_timing, timing);
  endtask

  // ********************************************************
  // clock, watchdog and main sequence
  // ********************************************************
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // whole run is well under 1000 cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      test_done;
    end
  end

  initial begin
    reset = 1'b1;
    host = '0;
    auto_timing = 33'h0aaaaaaaa;
    raw_sample = 12'h3c1;
    repeat (5) @(posedge core_clk);
    #1;
    reset = 1'b0;
    tick;
    reset_values;
    override_each;
    raw_justify;
    unmapped;
    test_done;
  end
endmodule
